// ===== src/ecb_pkg.sv
// package for the extended configuration bank: offsets, fields, reset values
// assumes a 32-bit word-addressed configuration port with byte offsets
package ecb_pkg;
  localparam logic [11:0] OFF_FIRST_ERR   = 12'h138;
  localparam logic [11:0] OFF_HDR_LOG0    = 12'h13C;
  localparam logic [11:0] OFF_HDR_LOG1    = 12'h140;
  localparam logic [11:0] OFF_HDR_LOG2    = 12'h144;
  localparam logic [11:0] OFF_HDR_LOG3    = 12'h148;
  localparam logic [11:0] OFF_CHAN_HDR    = 12'h150;
  localparam logic [11:0] OFF_PORT_CAP1   = 12'h154;
  localparam logic [11:0] OFF_PORT_CAP2   = 12'h158;
  localparam logic [11:0] OFF_PORT_CTRL   = 12'h15C;
  localparam logic [11:0] OFF_CH0_CAP     = 12'h160;
  localparam logic [11:0] OFF_CH0_CTRL    = 12'h164;
  localparam logic [11:0] OFF_CH0_STAT    = 12'h168;
  localparam logic [11:0] OFF_AUX_PIN     = 12'h304;
  localparam logic [11:0] OFF_ERR_CLEAR   = 12'h30C;
  localparam logic [15:0] CHAN_CAP_ID     = 16'h0002;
  localparam logic [3:0]  CHAN_CAP_VER    = 4'h1;
  localparam logic [11:0] NEXT_CAP_PTR    = 12'h000;
  localparam logic [6:0]  TC_MAP_RESET    = 7'h7F;
  localparam int          AUX_CLR_LSB     = 0;
  localparam int          AUX_SET_LSB     = 4;
  localparam int          AUX_ENCLR_LSB   = 8;
  localparam int          AUX_ENSET_LSB   = 12;
  localparam int          AUX_IN_LSB      = 16;
  localparam int          CH0_EN_BIT      = 31;
endpackage

// ===== src/ecb_regs.sv
// extended configuration bank: first-error pointer, header log, channel
// capability words and the auxiliary output/input register
// assumes error events and bus samples arrive on clock_i from the bridge core
//
// Operation
// [R1] five-bit read-only first error pointer, upper zero
// [R2] log bits 35:0 hold attribute phase
// [R3] log bits 39:36 hold first command
// [R4] log bits 43:40 hold second command
// [R5] log 95:64 first address; 63:44 zero
// [R6] log 127:96 second address; read-only
// [R7] capability identifier reads 0002h
// [R8] capability version reads 1h
// [R9] next capability pointer reads zero
// [R10] first port capability reads zero
// [R11] second port capability reads zero
// [R12] port control and status read zero
// [R13] channel-zero resource capability reads zero
// [R14] map bit0 one, 7:1 writable, enable one
// [R15] channel-zero resource status reads zero
// [R16] write one to 3:0 clears output
// [R17] write one to 7:4 sets output
// [R18] write one to 11:8 clears enable
// [R19] write one to 15:12 sets enable
// [R20] bits 19:16 show sampled inputs
// [R21] both fields read value; clear wins
// [R22] first error loads log, held until cleared
// [R23] output driven only while enabled
`default_nettype none

module ecb_regs
(
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  // register port
  input  wire logic [11:0]  addr_i,
  input  wire logic [31:0]  wdata_i,
  input  wire logic         write_i,
  input  wire logic         read_i,
  output logic      [31:0]  rdata_o,
  // error capture from the secondary-side detector
  input  wire logic         err_event_i,
  input  wire logic [4:0]   err_pointer_i,
  input  wire logic [35:0]  err_attr_i,
  input  wire logic [3:0]   err_cmd_first_i,
  input  wire logic [3:0]   err_cmd_second_i,
  input  wire logic [31:0]  err_addr_first_i,
  input  wire logic [31:0]  err_addr_second_i,
  output logic              err_logged_o,
  // auxiliary pins
  input  wire logic [3:0]   auxiliary_input_i,
  output logic      [3:0]   auxiliary_output_o,
  output logic      [3:0]   auxiliary_output_drive_enable_o
);

  logic [4:0]   first_err_ptr;
  logic [127:0] hdr_log;
  logic         log_held;
  logic [6:0]   tc_map;
  logic [3:0]   aux_out;
  logic [3:0]   aux_en;
  logic [3:0]   aux_in_meta;
  logic [3:0]   aux_in_sync;
  logic [31:0]  next_rdata;
  logic         wr_aux;
  logic         wr_clear;

  // one helper so all write and check decodes share the same compare
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  assign wr_aux   = write_i && hit(addr_i, ecb_pkg::OFF_AUX_PIN);
  assign wr_clear = write_i && hit(addr_i, ecb_pkg::OFF_ERR_CLEAR) && wdata_i[0];

  // capture on the first error only; the log stays frozen so software sees
  // the transaction that started the trouble, not the latest one
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      first_err_ptr <= 5'h00;
      hdr_log       <= 128'h0;
      log_held      <= 1'b0;
    end
    else if (err_event_i && !log_held)
    begin
      first_err_ptr    <= err_pointer_i;                         // [R1] [R22]
      hdr_log[35:0]    <= err_attr_i;                            // [R2]
      hdr_log[39:36]   <= err_cmd_first_i;                       // [R3]
      hdr_log[43:40]   <= err_cmd_second_i;                      // [R4]
      hdr_log[63:44]   <= 20'h00000;                             // [R5]
      hdr_log[95:64]   <= err_addr_first_i;                      // [R5]
      hdr_log[127:96]  <= err_addr_second_i;                     // [R6]
      log_held         <= 1'b1;                                  // [R22]
    end
    else if (wr_clear && !err_event_i)
    begin
      log_held <= 1'b0;                                          // [R22]
    end
  end

  assign err_logged_o = log_held;

  // traffic-class map, the only plain read/write field of the bank
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      tc_map <= ecb_pkg::TC_MAP_RESET;
    else if (write_i && hit(addr_i, ecb_pkg::OFF_CH0_CTRL))
      tc_map <= wdata_i[7:1];                                    // [R14]
  end

  // set/clear pairs; clear applied after set so clear wins on a collision
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      aux_out <= 4'h0;
      aux_en  <= 4'h0;
    end
    else if (wr_aux)
    begin
      aux_out <= (aux_out | wdata_i[ecb_pkg::AUX_SET_LSB +: 4])  // [R17]
                 & ~wdata_i[ecb_pkg::AUX_CLR_LSB +: 4];          // [R16] [R21]
      aux_en  <= (aux_en | wdata_i[ecb_pkg::AUX_ENSET_LSB +: 4]) // [R19]
                 & ~wdata_i[ecb_pkg::AUX_ENCLR_LSB +: 4];        // [R18] [R21]
    end
  end

  // pins are asynchronous to the core clock: two flops before use
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      aux_in_meta <= 4'h0;
      aux_in_sync <= 4'h0;
    end
    else
    begin
      aux_in_meta <= auxiliary_input_i;
      aux_in_sync <= aux_in_meta;
    end
  end

  // pad takes value only where enabled; the pad itself floats otherwise
  assign auxiliary_output_o              = aux_out & aux_en;     // [R23]
  assign auxiliary_output_drive_enable_o = aux_en;               // [R23]

  // read mux; every unlisted word, reserved ones included, returns zero
  always_comb
  begin
    next_rdata = 32'h0;
    case (addr_i[11:2])
      ecb_pkg::OFF_FIRST_ERR[11:2]: next_rdata = {27'h0, first_err_ptr};  // [R1]
      ecb_pkg::OFF_HDR_LOG0[11:2]:  next_rdata = hdr_log[31:0];
      ecb_pkg::OFF_HDR_LOG1[11:2]:  next_rdata = hdr_log[63:32];          // [R5]
      ecb_pkg::OFF_HDR_LOG2[11:2]:  next_rdata = hdr_log[95:64];
      ecb_pkg::OFF_HDR_LOG3[11:2]:  next_rdata = hdr_log[127:96];         // [R6]
      ecb_pkg::OFF_CHAN_HDR[11:2]:
        next_rdata = {ecb_pkg::NEXT_CAP_PTR, ecb_pkg::CHAN_CAP_VER,
                      ecb_pkg::CHAN_CAP_ID};                    // [R7] [R8] [R9]
      ecb_pkg::OFF_PORT_CAP1[11:2]: next_rdata = 32'h0;                   // [R10]
      ecb_pkg::OFF_PORT_CAP2[11:2]: next_rdata = 32'h0;                   // [R11]
      ecb_pkg::OFF_PORT_CTRL[11:2]: next_rdata = 32'h0;                   // [R12]
      ecb_pkg::OFF_CH0_CAP[11:2]:   next_rdata = 32'h0;                   // [R13]
      ecb_pkg::OFF_CH0_CTRL[11:2]:
        next_rdata = {1'b1, 23'h0, tc_map, 1'b1};                         // [R14]
      ecb_pkg::OFF_CH0_STAT[11:2]:  next_rdata = 32'h0;                   // [R15]
      ecb_pkg::OFF_AUX_PIN[11:2]:
        next_rdata = {12'h0, aux_in_sync, aux_en, aux_en,
                      aux_out, aux_out};                        // [R20] [R21]
      default:                      next_rdata = 32'h0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_o <= 32'h0;
    else if (read_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= 32'h0;
  end

  a_log_freeze: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R22]
    log_held && !wr_clear |=> $stable(hdr_log) && $stable(first_err_ptr))
    else $error("header log changed while held");

  a_log_capture: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R2]
    err_event_i && !log_held |=> hdr_log[35:0] == $past(err_attr_i)
      && hdr_log[95:64] == $past(err_addr_first_i))
    else $error("header log not captured");

  a_log_cmds: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R3]
    err_event_i && !log_held |=> hdr_log[43:36] ==
      {$past(err_cmd_second_i), $past(err_cmd_first_i)} && hdr_log[63:44] == 20'h0)
    else $error("command fields not captured");

  a_aux_clear_wins: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R21]
    wr_aux |=> (aux_out & $past(wdata_i[3:0])) == 4'h0
      && (aux_en & $past(wdata_i[11:8])) == 4'h0)
    else $error("clear did not win");

  a_aux_set: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R17]
    wr_aux |=> ((aux_out ^ $past(aux_out)) & ~$past(wdata_i[7:4])
      & ~$past(wdata_i[3:0])) == 4'h0)
    else $error("output bit changed without a one written");

  a_aux_drive: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R23]
    (auxiliary_output_o & ~auxiliary_output_drive_enable_o) == 4'h0)
    else $error("output value without enable");

  a_read_cap_hdr: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R7]
    read_i && hit(addr_i, ecb_pkg::OFF_CHAN_HDR) |=> rdata_o == 32'h00010002)
    else $error("capability header wrong");

  a_read_ch0_ctrl: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R14]
    read_i && hit(addr_i, ecb_pkg::OFF_CH0_CTRL) |=> rdata_o[31] && rdata_o[0]
      && rdata_o[30:8] == 23'h0)
    else $error("channel control fixed bits wrong");

  a_read_in_pins: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R20]
    read_i && hit(addr_i, ecb_pkg::OFF_AUX_PIN) |=> rdata_o[19:16] == $past(aux_in_sync)
      && rdata_o[31:20] == 12'h0)
    else $error("input field wrong");

  // register port checks: a strobe in one cycle, the answer judged one edge later;
  // the answer is held against the stored state or a fixed value, never against the mux

  // a read strobe aimed at one word
  sequence s_read_of(logic [11:0] off);
    read_i && hit(addr_i, off);
  endsequence

  // a write strobe aimed at one word
  sequence s_write_of(logic [11:0] off);
    write_i && hit(addr_i, off);
  endsequence

  // an error accepted for capture: only the first one while nothing is held
  sequence s_log_take;
    err_event_i && !log_held;
  endsequence

  // a clear that really releases the log: no event competes in that cycle
  sequence s_log_release;
    log_held && wr_clear && !err_event_i;
  endsequence

  // without a read strobe the data port must fall back to zero
  a_rdata_idle: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !read_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read");

  // pointer word: five stored bits, everything above reads zero
  a_read_first_err: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R1]
    s_read_of(ecb_pkg::OFF_FIRST_ERR) |=> rdata_o == {27'h0, $past(first_err_ptr)})
    else $error("first error pointer word wrong");

  // lowest log word carries the attribute phase
  a_read_log_low: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R2]
    s_read_of(ecb_pkg::OFF_HDR_LOG0) |=> rdata_o == $past(hdr_log[31:0]))
    else $error("log word zero wrong");

  // second log word: both commands, reserved bits zero
  a_read_log_cmds: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R4] [R5]
    s_read_of(ecb_pkg::OFF_HDR_LOG1) |=> rdata_o[31:12] == 20'h0
      && rdata_o[11:0] == $past(hdr_log[43:32]))
    else $error("log word one wrong");

  // third log word: first address phase
  a_read_log_addr1: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R5]
    s_read_of(ecb_pkg::OFF_HDR_LOG2) |=> rdata_o == $past(hdr_log[95:64]))
    else $error("log word two wrong");

  // fourth log word: second address phase
  a_read_log_addr2: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R6]
    s_read_of(ecb_pkg::OFF_HDR_LOG3) |=> rdata_o == $past(hdr_log[127:96]))
    else $error("log word three wrong");

  // a single channel with nothing extra to report
  a_read_port_cap1: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R10]
    s_read_of(ecb_pkg::OFF_PORT_CAP1) |=> rdata_o == 32'h0)
    else $error("first port capability not zero");

  // no arbitration capability, no table
  a_read_port_cap2: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R11]
    s_read_of(ecb_pkg::OFF_PORT_CAP2) |=> rdata_o == 32'h0)
    else $error("second port capability not zero");

  // control and status share a word and both read zero
  a_read_port_ctrl: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R12]
    s_read_of(ecb_pkg::OFF_PORT_CTRL) |=> rdata_o == 32'h0)
    else $error("port control word not zero");

  // channel-zero resources: nothing advertised
  a_read_ch0_cap: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R13]
    s_read_of(ecb_pkg::OFF_CH0_CAP) |=> rdata_o == 32'h0)
    else $error("channel-zero capability not zero");

  // negotiation never pending, table status never set
  a_read_ch0_stat: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R15]
    s_read_of(ecb_pkg::OFF_CH0_STAT) |=> rdata_o == 32'h0)
    else $error("channel-zero status not zero");

  // the writable map bits come back as stored
  a_read_ch0_map: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R14]
    s_read_of(ecb_pkg::OFF_CH0_CTRL) |=> rdata_o[7:1] == $past(tc_map))
    else $error("traffic map read wrong");

  // the auxiliary word returns each stored field twice
  a_read_aux_fields: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R21]
    s_read_of(ecb_pkg::OFF_AUX_PIN) |=> rdata_o[15:0] ==
      {$past(aux_en), $past(aux_en), $past(aux_out), $past(aux_out)})
    else $error("auxiliary fields read wrong");

  // a write to the control word loads bits 7:1 and nothing else
  a_map_write: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R14]
    s_write_of(ecb_pkg::OFF_CH0_CTRL) |=> tc_map == $past(wdata_i[7:1]))
    else $error("traffic map not written");

  // writes elsewhere leave the map alone
  a_map_hold: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R14]
    !s_write_of(ecb_pkg::OFF_CH0_CTRL) |=> $stable(tc_map))
    else $error("traffic map changed without a write");

  // error capture checks: the log is loaded on the first error and frozen until a clean clear

  // the second command phase lands in its own nibble
  a_log_second_cmd: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R4]
    s_log_take |=> hdr_log[43:40] == $past(err_cmd_second_i))
    else $error("second command not captured");

  // the second address phase lands in the top word
  a_log_addr2: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R6]
    s_log_take |=> hdr_log[127:96] == $past(err_addr_second_i))
    else $error("second address not captured");

  // the pointer is loaded with the log
  a_log_pointer: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R1]
    s_log_take |=> first_err_ptr == $past(err_pointer_i))
    else $error("first error pointer not loaded");

  // capture raises the held flag for software
  a_log_held_set: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R22]
    s_log_take |=> err_logged_o)
    else $error("held flag not raised on capture");

  // a clean clear lets the next error in
  a_log_release: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R22]
    s_log_release |=> !err_logged_o)
    else $error("held flag not released by clear");

  // a clear that meets an event is ignored, so the flag survives
  a_log_clear_lost: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R22]
    log_held && err_event_i |=> err_logged_o)
    else $error("held flag dropped while an event arrived");

  // auxiliary register checks: set and clear strobes per bit, the input synchroniser and the pin drive

  // a set bit ends up one unless its clear bit was also written
  a_aux_out_set: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R17]
    wr_aux |=> (~aux_out & $past(wdata_i[7:4]) & ~$past(wdata_i[3:0])) == 4'h0)
    else $error("output bit not set");

  // enable bits move only where a one was written
  a_aux_en_only: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R18]
    wr_aux |=> ((aux_en ^ $past(aux_en)) & ~$past(wdata_i[15:12])
      & ~$past(wdata_i[11:8])) == 4'h0)
    else $error("enable bit changed without a one written");

  // an enable set bit ends up one unless its clear bit was also written
  a_aux_en_set: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R19]
    wr_aux |=> (~aux_en & $past(wdata_i[15:12]) & ~$past(wdata_i[11:8])) == 4'h0)
    else $error("enable bit not set");

  // without a write to the auxiliary word nothing moves
  a_aux_hold: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R16]
    !wr_aux |=> $stable(aux_out) && $stable(aux_en))
    else $error("auxiliary state changed without a write");

  // the second synchroniser stage follows the first by one edge
  a_sync_stage: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R20]
    aux_in_sync == $past(aux_in_meta))
    else $error("input synchroniser skipped a stage");

  // the enable port mirrors the stored enables exactly
  a_drive_enable: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R23]
    auxiliary_output_drive_enable_o == aux_en
      && auxiliary_output_o == (aux_out & aux_en))
    else $error("pin drive does not follow stored state");

endmodule // ecb_regs

`default_nettype wire

// ===== verification/test_ecb_regs.sv
// self-checking bench for the extended configuration bank
// assumes ecb_regs is compiled first; the bench drives every port itself
`default_nettype none
module test_ecb_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [11:0] a; logic [31:0] d;} ecb_row_s;
  logic        clock_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0;
  logic        write_i = 1'b0;
  logic        read_i = 1'b0;
  logic [31:0] rdata_o;
  logic        err_event_i = 1'b0;
  logic [4:0]  err_pointer_i = 5'h00;
  logic [35:0] err_attr_i = 36'h0;
  logic [3:0]  err_cmd_first_i = 4'h0;
  logic [3:0]  err_cmd_second_i = 4'h0;
  logic [31:0] err_addr_first_i = 32'h0;
  logic [31:0] err_addr_second_i = 32'h0;
  logic        err_logged_o;
  logic [3:0]  auxiliary_input_i = 4'h0;
  logic [3:0]  auxiliary_output_o;
  logic [3:0]  auxiliary_output_drive_enable_o;
  int          miscompares = 0;
  int          n_compared = 0;
  // fixed words: read, attempt an all-ones write, read again; 200h is unmapped
  ecb_row_s rows [14] = '{'{12'h138, 32'h0}, '{12'h13C, 32'h0}, '{12'h140, 32'h0},
    '{12'h144, 32'h0}, '{12'h148, 32'h0}, '{12'h150, 32'h00010002}, '{12'h154, 32'h0},
    '{12'h158, 32'h0}, '{12'h15C, 32'h0}, '{12'h160, 32'h0}, '{12'h164, 32'h800000FF},
    '{12'h168, 32'h0}, '{12'h304, 32'h0}, '{12'h200, 32'h0}};

  ecb_regs ecb_regs_i (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
    .err_event_i(err_event_i), .err_pointer_i(err_pointer_i), .err_attr_i(err_attr_i),
    .err_cmd_first_i(err_cmd_first_i), .err_cmd_second_i(err_cmd_second_i),
    .err_addr_first_i(err_addr_first_i), .err_addr_second_i(err_addr_second_i),
    .err_logged_o(err_logged_o), .auxiliary_input_i(auxiliary_input_i),
    .auxiliary_output_o(auxiliary_output_o),
    .auxiliary_output_drive_enable_o(auxiliary_output_drive_enable_o));

  // 40 MHz core clock
  always #12.5 clock_i = ~clock_i;

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // reset low for 16 cycles, then let the input synchroniser refill
  task automatic do_reset();
    resetn_i <= 1'b0;
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clock_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1;
    chk("rdata", rdata_o, e);
  endtask

  // one-cycle error event; the log is expected to show {c2,c1,at} layout
  task automatic fire(input logic [4:0] p, input logic [35:0] at, input logic [3:0] c1,
                      input logic [3:0] c2, input logic [31:0] a1, input logic [31:0] a2);
    @(posedge clock_i);
    err_pointer_i     <= p;
    err_attr_i        <= at;
    err_cmd_first_i   <= c1;
    err_cmd_second_i  <= c2;
    err_addr_first_i  <= a1;
    err_addr_second_i <= a2;
    err_event_i       <= 1'b1;
    @(posedge clock_i);
    err_event_i <= 1'b0;
    #1;
    chk("err_logged", {31'h0, err_logged_o}, 32'h1);
  endtask

  task automatic log_chk(input logic [4:0] p, input logic [35:0] at, input logic [3:0] c1,
                         input logic [3:0] c2, input logic [31:0] a1, input logic [31:0] a2);
    rd(12'h138, {27'h0, p});
    rd(12'h13C, at[31:0]);
    rd(12'h140, {20'h0, c2, c1, at[35:32]});
    rd(12'h144, a1);
    rd(12'h148, a2);
  endtask

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    do_reset();
    chk("aux_en", {28'h0, auxiliary_output_drive_enable_o}, 32'h0);
    foreach (rows[i])
    begin
      rd(rows[i].a, rows[i].d);
      wr(rows[i].a, 32'hFFFFFFFF);
      rd(rows[i].a, rows[i].d);
    end
    // set enables and values, then clear with value set but enable off
    wr(12'h304, 32'h0000F0A0);
    rd(12'h304, 32'h0000FFAA);
    chk("aux_out", {28'h0, auxiliary_output_o}, 32'hA);
    wr(12'h304, 32'h00000C02);
    rd(12'h304, 32'h00003388);
    chk("aux_out", {28'h0, auxiliary_output_o}, 32'h0);
    wr(12'h304, 32'h00001111);
    rd(12'h304, 32'h00002288);
    chk("aux_en", {28'h0, auxiliary_output_drive_enable_o}, 32'h2);
    auxiliary_input_i <= 4'h5;
    repeat (3) @(posedge clock_i);
    rd(12'h304, 32'h00052288);
    // capture, ignore a second event, clear, capture again
    fire(5'h15, 36'hA12345678, 4'h3, 4'hC, 32'h89ABCDEF, 32'h02468ACE);
    fire(5'h1F, 36'h0, 4'h0, 4'h0, 32'h0, 32'h0);
    log_chk(5'h15, 36'hA12345678, 4'h3, 4'hC, 32'h89ABCDEF, 32'h02468ACE);
    wr(12'h30C, 32'h00000001);
    #1;
    chk("err_logged", {31'h0, err_logged_o}, 32'h0);
    fire(5'h0A, 36'h5EDCBA987, 4'hF, 4'h1, 32'hFFFFFFFF, 32'h13579BDF);
    log_chk(5'h0A, 36'h5EDCBA987, 4'hF, 4'h1, 32'hFFFFFFFF, 32'h13579BDF);
    wr(12'h164, 32'h0);
    rd(12'h164, 32'h80000001);
    // reset in mid-run brings the map and the log back
    do_reset();
    rd(12'h164, 32'h800000FF);
    rd(12'h148, 32'h0);
    rd(12'h304, 32'h00050000);
    report_and_stop();
  end
endmodule // test_ecb_regs
`default_nettype wire
